// ==== design/pecr_cfg.svh ====
// Offsets, field positions, reset values and fixed codes of the capability bank
`ifndef PECR_CFG_SVH
`define PECR_CFG_SVH

`define PECR_ADDR_W            12
`define PECR_OFF_ERR_HDR1      12'h11C
`define PECR_OFF_ERR_HDR2      12'h120
`define PECR_OFF_ERR_HDR3      12'h124
`define PECR_OFF_ERR_HDR4      12'h128
`define PECR_OFF_SERIAL_HDR    12'h180
`define PECR_OFF_SERIAL_LOW    12'h184
`define PECR_OFF_SERIAL_HIGH   12'h188
`define PECR_OFF_CHAN_HDR      12'h200
`define PECR_OFF_CHAN_CAPS_A   12'h204
`define PECR_OFF_CHAN_CAPS_B   12'h208

`define PECR_KIND_LSB          0
`define PECR_REV_LSB           16
`define PECR_LINK_LSB          20
`define PECR_SERIAL_KIND       16'h0003
`define PECR_CHAN_KIND         16'h0002
`define PECR_STRUCT_REV        4'h1
`define PECR_SERIAL_LINK_RST   12'h200
`define PECR_CHAN_LINK_RST     12'h000
`define PECR_SERIAL_RST        32'h0000_0000
`define PECR_HDR_RST           32'h0000_0000

`define PECR_EXTRA_CHAN_LSB    0
`define PECR_LOW_GROUP_LSB     4
`define PECR_TIME_BASE_LSB     8
`define PECR_ENTRY_BITS_LSB    10
`define PECR_EXTRA_CHAN_VAL    3'h1
`define PECR_LOW_GROUP_VAL     3'h0
`define PECR_TIME_BASE_VAL     2'h0
`define PECR_ENTRY_BITS_VAL    2'h2
`define PECR_GRANT_SCHEMES_VAL 8'h00

`endif

// ==== design/pecr_pkg.sv ====
// Types shared by the capability bank
package pecr_pkg;
  typedef enum logic [1:0] {
    PECR_LOG_IDLE = 2'b00,
    PECR_LOG_HELD = 2'b01
  } pecr_log_state_t;
  typedef logic [31:0] pecr_word_t;
endpackage : pecr_pkg

// ==== design/pecr_header_log.sv ====
// First-error TLP header capture with sticky hold
`timescale 1ns/10ps
`include "pecr_cfg.svh"
module pecr_header_log
  import pecr_pkg::*;
(
  input  wire logic        clk_sys,
  input  wire logic        nrst_sticky,
  input  wire logic        err_report,
  input  wire pecr_word_t  err_hdr_w1,
  input  wire pecr_word_t  err_hdr_w2,
  input  wire pecr_word_t  err_hdr_w3,
  input  wire pecr_word_t  err_hdr_w4,
  input  wire logic        err_release,
  output logic [127:0]     captured_header,
  output logic             log_held
);
  pecr_log_state_t state_reg;
  pecr_log_state_t state_next;
  logic [127:0]    hdr_reg;
  wire             take_w;

  // Capture only when no earlier record is held
  assign take_w = (state_reg == PECR_LOG_IDLE) && err_report;

  always_comb begin
    case (state_reg)
      PECR_LOG_IDLE: state_next = take_w ? PECR_LOG_HELD : PECR_LOG_IDLE;
      PECR_LOG_HELD: state_next = err_release ? PECR_LOG_IDLE : PECR_LOG_HELD;
      default:       state_next = PECR_LOG_IDLE;
    endcase
  end

  always_ff @(posedge clk_sys or negedge nrst_sticky) begin
    if (!nrst_sticky) begin
      state_reg <= PECR_LOG_IDLE;
      hdr_reg   <= {4{`PECR_HDR_RST}};
    end else begin
      state_reg <= state_next;
      if (take_w) begin
        hdr_reg <= {err_hdr_w4, err_hdr_w3, err_hdr_w2, err_hdr_w1};
      end
    end
  end

  assign captured_header = hdr_reg;
  assign log_held        = (state_reg == PECR_LOG_HELD);
endmodule : pecr_header_log

// ==== design/pecr_regs.sv ====
// Extended capability register bank: header log, serial number, channel caps
// Notes on behaviour
// - First uncorrectable error captures four header words
// - Serial structure kind code reads 0x3
// - Both structure headers report revision 0x1
// - Chain offsets default 0x200 then 0x0
// - Low serial word holds unique id low half
// - High serial word holds unique id high half
// - Channel structure kind code reads 0x2
// - Extra channel total reads 0x1
// - Low group channel total reads 0x0
// - Weighted slot time base reads 0x0
// - Port table entry bits reads 0x2
// - Channel grant schemes reads 0x0
//
// Local design decision: the plain strobed port.
`timescale 1ns/10ps
`include "pecr_cfg.svh"
module pecr_regs
  import pecr_pkg::*;
(
  input  wire logic                      clk_sys,
  input  wire logic                      nrst,
  input  wire logic                      nrst_sticky,
  input  wire logic [`PECR_ADDR_W-1:0]   reg_addr,
  input  wire pecr_word_t                reg_wdata,
  input  wire logic                      reg_wr,
  input  wire logic                      reg_rd,
  output pecr_word_t                     reg_rdata,
  input  wire logic                      cfg_unlock,
  input  wire logic                      err_report,
  input  wire pecr_word_t                err_hdr_w1,
  input  wire pecr_word_t                err_hdr_w2,
  input  wire pecr_word_t                err_hdr_w3,
  input  wire pecr_word_t                err_hdr_w4,
  input  wire logic                      err_release,
  output logic                           log_held,
  output logic [63:0]                    unique_id
);
  logic [11:0]  serial_link_reg;
  logic [11:0]  chan_link_reg;
  pecr_word_t   unique_id_low_reg;
  pecr_word_t   unique_id_high_reg;
  pecr_word_t   rdata_reg;
  logic         held_reg;
  logic [63:0]  uid_reg;
  logic [127:0] captured_header;
  logic         log_held_w;

  function automatic pecr_word_t struct_header(input logic [15:0] kind,
                                               input logic [11:0] link);
    struct_header = {link, `PECR_STRUCT_REV, kind};
  endfunction : struct_header

  pecr_header_log u_log (
    .clk_sys         (clk_sys),
    .nrst_sticky     (nrst_sticky),
    .err_report      (err_report),
    .err_hdr_w1      (err_hdr_w1),
    .err_hdr_w2      (err_hdr_w2),
    .err_hdr_w3      (err_hdr_w3),
    .err_hdr_w4      (err_hdr_w4),
    .err_release     (err_release),
    .captured_header (captured_header),
    .log_held        (log_held_w)
  );

  // Address decode
  wire sel_h1   = (reg_addr == `PECR_OFF_ERR_HDR1);
  wire sel_h2   = (reg_addr == `PECR_OFF_ERR_HDR2);
  wire sel_h3   = (reg_addr == `PECR_OFF_ERR_HDR3);
  wire sel_h4   = (reg_addr == `PECR_OFF_ERR_HDR4);
  wire sel_shdr = (reg_addr == `PECR_OFF_SERIAL_HDR);
  wire sel_slo  = (reg_addr == `PECR_OFF_SERIAL_LOW);
  wire sel_shi  = (reg_addr == `PECR_OFF_SERIAL_HIGH);
  wire sel_chdr = (reg_addr == `PECR_OFF_CHAN_HDR);
  wire sel_ca   = (reg_addr == `PECR_OFF_CHAN_CAPS_A);
  wire sel_cb   = (reg_addr == `PECR_OFF_CHAN_CAPS_B);

  // Lockable fields take writes only while unlocked
  wire wr_ok      = reg_wr && cfg_unlock;
  wire wr_slink   = wr_ok && sel_shdr;
  wire wr_clink   = wr_ok && sel_chdr;
  wire wr_slo     = wr_ok && sel_slo;
  wire wr_shi     = wr_ok && sel_shi;

  wire pecr_word_t serial_hdr_w = struct_header(`PECR_SERIAL_KIND, serial_link_reg);
  wire pecr_word_t chan_hdr_w   = struct_header(`PECR_CHAN_KIND, chan_link_reg);

  // Fixed capability words; unlisted bits are reserved zero
  wire pecr_word_t caps_a_w = {20'h00000,
                               `PECR_ENTRY_BITS_VAL,
                               `PECR_TIME_BASE_VAL,
                               1'b0,
                               `PECR_LOW_GROUP_VAL,
                               1'b0,
                               `PECR_EXTRA_CHAN_VAL};
  wire pecr_word_t caps_b_w = {24'h000000, `PECR_GRANT_SCHEMES_VAL};

  wire pecr_word_t rd_mux_w =
      sel_h1   ? captured_header[31:0]   :
      sel_h2   ? captured_header[63:32]  :
      sel_h3   ? captured_header[95:64]  :
      sel_h4   ? captured_header[127:96] :
      sel_shdr ? serial_hdr_w            :
      sel_slo  ? unique_id_low_reg       :
      sel_shi  ? unique_id_high_reg      :
      sel_chdr ? chan_hdr_w              :
      sel_ca   ? caps_a_w                :
      sel_cb   ? caps_b_w                :
      32'h0000_0000;

  // Chain links reset with the function reset
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      serial_link_reg <= `PECR_SERIAL_LINK_RST;
      chan_link_reg   <= `PECR_CHAN_LINK_RST;
      rdata_reg       <= 32'h0000_0000;
      held_reg        <= 1'b0;
      uid_reg         <= 64'h0000_0000_0000_0000;
    end else begin
      if (wr_slink) begin
        serial_link_reg <= reg_wdata[31:20];
      end
      if (wr_clink) begin
        chan_link_reg <= reg_wdata[31:20];
      end
      rdata_reg <= reg_rd ? rd_mux_w : 32'h0000_0000;
      held_reg  <= log_held_w;
      uid_reg   <= {unique_id_high_reg, unique_id_low_reg};
    end
  end

  // Serial number survives non-power resets
  always_ff @(posedge clk_sys or negedge nrst_sticky) begin
    if (!nrst_sticky) begin
      unique_id_low_reg  <= `PECR_SERIAL_RST;
      unique_id_high_reg <= `PECR_SERIAL_RST;
    end else begin
      if (wr_slo) begin
        unique_id_low_reg <= reg_wdata;
      end
      if (wr_shi) begin
        unique_id_high_reg <= reg_wdata;
      end
    end
  end

  assign reg_rdata = rdata_reg;
  assign log_held  = held_reg;
  assign unique_id = uid_reg;
endmodule : pecr_regs

// ==== bench/pecr_regs_properties.sv ====
// Concurrent checks on the ports of the capability register bank
`timescale 1ns/10ps
module pecr_regs_chk
  import pecr_pkg::*;
(
  input wire logic        clk_sys,
  input wire logic        nrst,
  input wire logic [11:0] reg_addr,
  input wire logic        reg_rd,
  input wire pecr_word_t  reg_rdata,
  input wire logic        err_report,
  input wire logic        err_release,
  input wire logic        log_held,
  input wire logic [63:0] unique_id
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!nrst);
  AST_RD_IDLE_ZERO: assert property (!reg_rd |=> reg_rdata == 32'h0)
    else $error("read data not zero outside a read");
  AST_SERIAL_HDR: assert property (reg_rd && reg_addr == 12'h180 |=>
    reg_rdata[19:0] == 20'h10003) else $error("serial header code wrong");
  AST_CHAN_HDR: assert property (reg_rd && reg_addr == 12'h200 |=>
    reg_rdata[19:0] == 20'h10002) else $error("channel header code wrong");
  AST_CAPS_A: assert property (reg_rd && reg_addr == 12'h204 |=>
    reg_rdata == 32'h0000_0801) else $error("channel caps a wrong");
  AST_CAPS_B: assert property (reg_rd && reg_addr == 12'h208 |=>
    reg_rdata == 32'h0) else $error("channel caps b wrong");
  AST_UID_LOW: assert property (reg_rd && reg_addr == 12'h184 |=>
    reg_rdata == unique_id[31:0]) else $error("low serial word differs from id");
  AST_UID_HIGH: assert property (reg_rd && reg_addr == 12'h188 |=>
    reg_rdata == unique_id[63:32]) else $error("high serial word differs from id");
  AST_LOG_HOLD: assert property (log_held && !err_release && !$past(err_release) |=>
    log_held) else $error("record dropped without release");
  AST_LOG_SET: assert property ($rose(log_held) |-> $past(err_report, 2) || !$past(nrst, 2))
    else $error("record appeared without an error report");
  cover property ($rose(log_held));
  cover property (err_release ##1 err_report);
  cover property (reg_rd && reg_addr == 12'h184);
endmodule : pecr_regs_chk

bind pecr_regs pecr_regs_chk u_chk (.clk_sys(clk_sys), .nrst(nrst), .reg_addr(reg_addr),
  .reg_rd(reg_rd), .reg_rdata(reg_rdata), .err_report(err_report),
  .err_release(err_release), .log_held(log_held), .unique_id(unique_id));

// ==== bench/tb_pcie_ext_cap_regs.sv ====
// Self-checking bench for the capability register bank
`timescale 1ns/10ps
module tb_pcie_ext_cap_regs;
  import pecr_pkg::*;
  logic        clk_sys = 0, nrst = 0, nrst_sticky = 0, reg_wr = 0, reg_rd = 0;
  logic        cfg_unlock = 0, err_report = 0, err_release = 0, log_held;
  logic [11:0] reg_addr = 0;
  pecr_word_t  reg_wdata = 0, reg_rdata, err_hdr_w1 = 0, err_hdr_w2 = 0;
  pecr_word_t  err_hdr_w3 = 0, err_hdr_w4 = 0, seed = 32'h33AE6B99, d, lo, hi, hw[4];
  logic [63:0] unique_id;
  int          error_cnt = 0, comparisons = 0;
  logic [11:0] offs[10] = '{12'h11C, 12'h120, 12'h124, 12'h128, 12'h180, 12'h184,
                            12'h188, 12'h200, 12'h204, 12'h208};
  pecr_word_t  dflt[10] = '{0, 0, 0, 0, 32'h2001_0003, 0, 0, 32'h0001_0002, 32'h801, 0};
  pecr_regs DUT (.clk_sys(clk_sys), .nrst(nrst), .nrst_sticky(nrst_sticky),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .cfg_unlock(cfg_unlock), .err_report(err_report),
    .err_hdr_w1(err_hdr_w1), .err_hdr_w2(err_hdr_w2), .err_hdr_w3(err_hdr_w3),
    .err_hdr_w4(err_hdr_w4), .err_release(err_release), .log_held(log_held),
    .unique_id(unique_id));
  initial begin
    forever #5 clk_sys = ~clk_sys;
  end
  function automatic pecr_word_t rnd();
    seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
    return seed;
  endfunction : rnd
  task chk(input pecr_word_t got, input pecr_word_t exp);
    comparisons++;
    if (got !== exp) begin
      error_cnt++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task rd(input logic [11:0] a, input pecr_word_t e);
    @(posedge clk_sys);
    reg_rd <= 1;
    reg_addr <= a;
    @(posedge clk_sys);
    reg_rd <= 0;
    #1 chk(reg_rdata, e);
  endtask : rd
  task wr(input logic [11:0] a, input pecr_word_t v);
    @(posedge clk_sys);
    reg_wr <= 1;
    reg_addr <= a;
    reg_wdata <= v;
    @(posedge clk_sys);
    reg_wr <= 0;
  endtask : wr
  task err(input bit ignored);
    pecr_word_t w[4];
    for (int i = 0; i < 4; i++) w[i] = rnd();
    if (!ignored) hw = w;
    @(posedge clk_sys);
    err_report <= 1'b1;
    {err_hdr_w1, err_hdr_w2, err_hdr_w3, err_hdr_w4} <= {w[0], w[1], w[2], w[3]};
    @(posedge clk_sys);
    err_report <= 0;
  endtask : err
  task logchk();
    for (int i = 0; i < 4; i++) rd(offs[i], hw[i]);
  endtask : logchk
  task rst(input bit sticky);
    @(posedge clk_sys);
    nrst <= 0;
    nrst_sticky <= !sticky;
    repeat (2) @(posedge clk_sys);
    {nrst, nrst_sticky} <= 2'b11;
  endtask : rst
  task print_verdict();
    $display("errors %0d comparisons %0d", error_cnt, comparisons);
    if (error_cnt == 0 && comparisons > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : print_verdict
  initial begin
    #500us error_cnt++;
    print_verdict();
  end
  initial begin
    repeat (6) @(posedge clk_sys);
    {nrst, nrst_sticky} <= 2'b11;
    for (int i = 0; i < 10; i++) rd(offs[i], dflt[i]);
    rd(12'h300, 0);
    rd(12'h18C, 0);
    wr(12'h184, rnd());
    rd(12'h184, 0);
    cfg_unlock <= 1;
    lo = rnd();
    hi = rnd();
    wr(12'h184, lo);
    wr(12'h188, hi);
    rd(12'h184, lo);
    rd(12'h188, hi);
    chk(unique_id[31:0], lo);
    chk(unique_id[63:32], hi);
    d = rnd();
    wr(12'h180, d);
    rd(12'h180, {d[31:20], 20'h10003});
    wr(12'h204, d);
    rd(12'h204, 32'h801);
    err(0);
    err(1);
    logchk();
    chk({31'h0, log_held}, 32'h1);
    @(posedge clk_sys) err_release <= 1;
    @(posedge clk_sys) err_release <= 0;
    err(0);
    logchk();
    rst(0);
    logchk();
    rd(12'h184, lo);
    rd(12'h180, 32'h2001_0003);
    rst(1);
    hw = '{0, 0, 0, 0};
    logchk();
    chk({31'h0, log_held}, 32'h0);
    rd(12'h188, 0);
    print_verdict();
  end
endmodule : tb_pcie_ext_cap_regs
